// *** bcr_board_regs.sv ***
`timescale 1ns/10ps
`include "bcr_consts.svh"

module bcr_board_regs #(
  parameter int unsigned WD_LONG_CYC  = `BCR_WD_LONG_MS * `BCR_CLK_KHZ,
  parameter int unsigned WD_SHORT_CYC = `BCR_WD_SHORT_MS * `BCR_CLK_KHZ,
  parameter logic [7:0]  REVISION     = `BCR_REVISION_DEF
) (
  // Clock and resets
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        power_on_n,
  // Host memory bus
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  // Board straps
  input  wire logic [1:0]  boot_switch_on,
  input  wire logic        option_jumper_closed,
  // Indicators and board reset
  output logic             ready_led,
  output logic             board_reset_out,
  // Two-wire lines, open collector
  input  wire logic        clk_line_i,
  output logic             clk_line_o,
  output logic             clk_line_oe,
  input  wire logic        dat_line_i,
  output logic             dat_line_o,
  output logic             dat_line_oe
);
  import bcr_pkg::*;

  localparam int CW = `BCR_WD_CNT_W;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // Register state.
  logic [7:0]          rdata_reg, rdata_next;
  logic                ready_reg, ready_next;
  logic                clk_out_latch_reg, clk_out_latch_next;
  logic                dat_out_latch_reg, dat_out_latch_next;
  logic                clk_pin_reg, dat_pin_reg;
  logic                clk_oe_reg, clk_oe_next;
  logic                dat_oe_reg, dat_oe_next;
  logic [1:0]          boot_select_inputs_reg;
  logic                jumper_reg;
  // Watchdog state.
  bcr_wd_state_t       wd_state_reg, wd_state_next;
  logic [CW-1:0]       wd_cnt_reg, wd_cnt_next;
  logic                wdog_kick_bit_reg, wdog_kick_bit_next;
  logic                wdog_expired_n_reg, wdog_expired_n_next;
  logic [4:0]          rst_cnt_reg, rst_cnt_next;
  logic                board_rst_reg;
  logic [CW-1:0]       wd_limit;

  logic wr_setup, wr_ctrl, wr_opt, wr_tw, bite;

  assign wr_setup = bus_wr && hit(bus_addr, `BCR_ADDR_SETUP);
  assign wr_ctrl  = bus_wr && hit(bus_addr, `BCR_ADDR_CONTROL);
  assign wr_opt   = bus_wr && hit(bus_addr, `BCR_ADDR_OPTION);
  assign wr_tw    = bus_wr && hit(bus_addr, `BCR_ADDR_TWO_WIRE);

  // The long count is a parameter so simulation can shrink it; the jumper picks one.
  assign wd_limit = jumper_reg ? CW'(WD_SHORT_CYC - 1) : CW'(WD_LONG_CYC - 1);

  // Register file: read mux and writable latches.
  always_comb begin
    ready_next         = ready_reg;
    clk_out_latch_next = clk_out_latch_reg;
    dat_out_latch_next = dat_out_latch_reg;
    rdata_next         = `BCR_RD_IDLE;
    if (wr_setup) begin
      ready_next = bus_wdata[`BCR_SETUP_READY_BIT];
    end
    if (wr_tw) begin
      clk_out_latch_next = bus_wdata[`BCR_TW_CLK_OUT_BIT];
      dat_out_latch_next = bus_wdata[`BCR_TW_DAT_OUT_BIT];
    end
    // The enables are registered copies so the pins come straight from flip-flops.
    clk_oe_next        = ~clk_out_latch_next;
    dat_oe_next        = ~dat_out_latch_next;
    if (bus_rd) begin
      unique case (bus_addr)
        `BCR_ADDR_STATUS: begin
          rdata_next = `BCR_STATUS_ONES;
          rdata_next[`BCR_STAT_EXPIRED_BIT] = wdog_expired_n_reg;
        end
        `BCR_ADDR_CONTROL: begin
          rdata_next = `BCR_CONTROL_ONES;
          rdata_next[`BCR_CTRL_KICK_BIT] = wdog_kick_bit_reg;
        end
        `BCR_ADDR_SETUP: begin
          rdata_next = 8'h00;
          rdata_next[`BCR_SETUP_READY_BIT] = ready_reg;
          rdata_next[`BCR_SETUP_WDOG_ENABLE_BIT_BIT]  = (wd_state_reg == BCR_WD_RUN);
        end
        `BCR_ADDR_REVISION: rdata_next = REVISION;
        `BCR_ADDR_BOOT_SEL: rdata_next = {6'h00, boot_select_inputs_reg};
        `BCR_ADDR_TWO_WIRE: begin
          rdata_next = {clk_out_latch_reg, dat_out_latch_reg, clk_pin_reg, dat_pin_reg,
                        `BCR_TW_LOW_ONES};
        end
        default: rdata_next = `BCR_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_reg              <= `BCR_RD_IDLE;
      ready_reg              <= 1'b0;
      clk_out_latch_reg      <= 1'b1;
      dat_out_latch_reg      <= 1'b1;
      clk_pin_reg            <= 1'b1;
      dat_pin_reg            <= 1'b1;
      clk_oe_reg             <= 1'b0;
      dat_oe_reg             <= 1'b0;
      boot_select_inputs_reg <= 2'h3;
      jumper_reg             <= 1'b0;
    end else begin
      rdata_reg              <= rdata_next;
      ready_reg              <= ready_next;
      clk_out_latch_reg      <= clk_out_latch_next;
      dat_out_latch_reg      <= dat_out_latch_next;
      clk_pin_reg            <= clk_line_i;
      dat_pin_reg            <= dat_line_i;
      clk_oe_reg             <= clk_oe_next;
      dat_oe_reg             <= dat_oe_next;
      // Only the on-on position selects the loader; every other setting boots normally.
      boot_select_inputs_reg <= {1'b1, ~(boot_switch_on[1] & boot_switch_on[0])};
      jumper_reg             <= option_jumper_closed;
    end
  end

  // Watchdog. The expiry flag lives on the power-on reset so it outlasts a bite.
  always_comb begin
    wd_state_next       = wd_state_reg;
    wd_cnt_next         = wd_cnt_reg;
    wdog_kick_bit_next  = wdog_kick_bit_reg;
    wdog_expired_n_next = wdog_expired_n_reg;
    rst_cnt_next        = (rst_cnt_reg != 5'h00) ? rst_cnt_reg - 5'h01 : 5'h00;
    bite                = 1'b0;
    if (wr_ctrl) begin
      wdog_kick_bit_next = bus_wdata[`BCR_CTRL_KICK_BIT];
    end
    unique case (wd_state_reg)
      BCR_WD_OFF: begin
        if (wr_setup && bus_wdata[`BCR_SETUP_WDOG_ENABLE_BIT_BIT]) begin
          wd_cnt_next = '0;
          if (!wdog_expired_n_reg) begin
            bite = 1'b1;
          end else begin
            wd_state_next = BCR_WD_RUN;
          end
        end
      end
      BCR_WD_RUN: begin
        // A zero in the enable bit is simply ignored here.
        if (wr_ctrl && (bus_wdata[`BCR_CTRL_KICK_BIT] != wdog_kick_bit_reg)) begin
          wd_cnt_next = '0;
        end else if (wd_cnt_reg >= wd_limit) begin
          bite = 1'b1;
        end else begin
          wd_cnt_next = wd_cnt_reg + CW'(1);
        end
      end
      BCR_WD_EXPIRED: begin
        wd_state_next = BCR_WD_EXPIRED;
      end
    endcase
    if (bite) begin
      wd_state_next       = BCR_WD_EXPIRED;
      wdog_expired_n_next = 1'b0;
      rst_cnt_next        = `BCR_RST_PULSE_CYC;
    end
    if (wr_opt && (bus_wdata == `BCR_HW_RESET_KEY)) begin
      wdog_expired_n_next = 1'b1;
      rst_cnt_next        = `BCR_RST_PULSE_CYC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wd_state_reg      <= BCR_WD_OFF;
      wd_cnt_reg        <= '0;
      wdog_kick_bit_reg <= 1'b0;
      rst_cnt_reg       <= 5'h00;
      board_rst_reg     <= 1'b0;
    end else begin
      wd_state_reg      <= wd_state_next;
      wd_cnt_reg        <= wd_cnt_next;
      wdog_kick_bit_reg <= wdog_kick_bit_next;
      rst_cnt_reg       <= rst_cnt_next;
      board_rst_reg     <= (rst_cnt_next != 5'h00);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!power_on_n) begin
      wdog_expired_n_reg <= 1'b1;
    end else begin
      wdog_expired_n_reg <= wdog_expired_n_next;
    end
  end

  // Lines are never driven high; a released latch lets the pull-up win.
  assign clk_line_o      = 1'b0;
  assign dat_line_o      = 1'b0;
  assign clk_line_oe     = clk_oe_reg;
  assign dat_line_oe     = dat_oe_reg;
  assign bus_rdata       = rdata_reg;
  assign ready_led       = ready_reg;
  assign board_reset_out = board_rst_reg;

  a_wdog_enable_bit_no_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wd_state_reg == BCR_WD_RUN) && wr_setup && !bus_wdata[6] |=> wd_state_reg != BCR_WD_OFF)
    else $error("watchdog stopped by software");
  a_ready_led_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_setup |=> ready_led == $past(bus_wdata[7]))
    else $error("ready led does not follow write");
  a_revision_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus_rd && (bus_addr == `BCR_ADDR_REVISION) |=> bus_rdata == REVISION)
    else $error("revision read wrong");
  a_boot_read_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus_rd && (bus_addr == `BCR_ADDR_BOOT_SEL) |=> bus_rdata[7:2] == 6'h00)
    else $error("boot select upper bits not zero");
  a_tw_line_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_tw |=> (clk_line_oe == !$past(bus_wdata[7])) && (dat_line_oe == !$past(bus_wdata[6])))
    else $error("two-wire latch drive wrong");
  a_tw_read_back: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus_rd && (bus_addr == `BCR_ADDR_TWO_WIRE) ##0 !wr_tw
    |=> bus_rdata == {!clk_line_oe, !dat_line_oe, $past(clk_pin_reg), $past(dat_pin_reg), 4'hf})
    else $error("two-wire read wrong");
  a_wd_off_reset: assert property (@(posedge sys_clk) disable iff (1'b0)
    !rstn |=> wd_state_reg == BCR_WD_OFF && !board_reset_out)
    else $error("watchdog not off after reset");
  a_wd_bite_out: assert property (@(posedge sys_clk) disable iff (!rstn || !power_on_n)
    (wd_state_reg == BCR_WD_RUN) && (wd_cnt_reg >= wd_limit) && !wr_ctrl && !wr_opt
    |=> board_reset_out && !wdog_expired_n_reg ##1 board_reset_out[*8])
    else $error("watchdog bite missing");
  a_wd_cnt_limit: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wd_state_reg == BCR_WD_RUN) && $stable(jumper_reg) |-> wd_cnt_reg <= wd_limit)
    else $error("watchdog count beyond timeout");
  a_wd_rebite: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wd_state_reg == BCR_WD_OFF) && !wdog_expired_n_reg && wr_setup && bus_wdata[6]
    |=> board_reset_out && wd_state_reg == BCR_WD_EXPIRED)
    else $error("no reset when enabling with flag set");
  a_kick_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wd_state_reg == BCR_WD_RUN) && wr_ctrl && (bus_wdata[6] != wdog_kick_bit_reg)
    |=> wd_cnt_reg == '0)
    else $error("kick did not restart timeout");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!power_on_n)
    !wdog_expired_n_reg && !(wr_opt && bus_wdata == 8'ha5) |=> !wdog_expired_n_reg)
    else $error("expiry flag lost");
  a_boot_map: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_switch_on == 2'h3 |=> boot_select_inputs_reg == 2'h2)
    else $error("boot switch mapping wrong");
endmodule

// *** bcr_consts.svh ***
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// Byte register addresses on the host memory bus.
`define BCR_ADDR_STATUS    32'h2000_8200
`define BCR_ADDR_CONTROL   32'h2000_8201
`define BCR_ADDR_OPTION    32'h2000_8204
`define BCR_ADDR_SETUP     32'h2000_8205
`define BCR_ADDR_REVISION  32'h2000_8206
`define BCR_ADDR_BOOT_SEL  32'h2000_820a
`define BCR_ADDR_TWO_WIRE  32'h2000_820b

// Field positions.
`define BCR_SETUP_READY_BIT   7
`define BCR_SETUP_WDOG_ENABLE_BIT_BIT    6
`define BCR_CTRL_KICK_BIT     6
`define BCR_STAT_EXPIRED_BIT  4
`define BCR_TW_CLK_OUT_BIT    7
`define BCR_TW_DAT_OUT_BIT    6
`define BCR_TW_CLK_PIN_BIT    5
`define BCR_TW_DAT_PIN_BIT    4

// Fixed read patterns and keys.
`define BCR_STATUS_ONES    8'hef
`define BCR_CONTROL_ONES   8'h85
`define BCR_TW_LOW_ONES    4'hf
`define BCR_RD_IDLE        8'h00
`define BCR_HW_RESET_KEY   8'ha5
`define BCR_REVISION_DEF   8'h01

// Timing.
`define BCR_CLK_KHZ        50000
`define BCR_WD_LONG_MS     1600
`define BCR_WD_SHORT_MS    100
`define BCR_WD_CNT_W       27
`define BCR_RST_PULSE_CYC  5'h10

`endif

// *** bcr_pkg.sv ***
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_WD_OFF     = 2'h0,
    BCR_WD_RUN     = 2'h1,
    BCR_WD_EXPIRED = 2'h3
  } bcr_wd_state_t;
endpackage

// *** bcr_tw_bus.sv ***
`timescale 1ns/10ps
module bcr_tw_bus (
  // Enables from the block and from the far device
  input  wire logic clk_oe,
  input  wire logic dat_oe,
  input  wire logic ext_clk_low,
  input  wire logic ext_dat_low,
  // Resolved line levels
  output logic      clk_level,
  output logic      dat_level
);
  // Pull-ups set the level, so a released line reads high and never keeps an old value.
  assign clk_level = ~(clk_oe | ext_clk_low);
  assign dat_level = ~(dat_oe | ext_dat_low);
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
`include "bcr_consts.svh"
module testbench;
  localparam int unsigned LONG_CYC  = 200;
  localparam int unsigned SHORT_CYC = 50;
  // Revision value is arbitrary.
  localparam logic [7:0]  REV       = 8'h3c;
  logic        sys_clk, rstn, power_on_n, bus_rd, bus_wr, jumper, ext_clk_low, ext_dat_low;
  logic        ready_led, board_reset_out, clk_o, clk_oe, dat_o, dat_oe, clk_level, dat_level;
  logic [31:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, rd_val;
  logic [1:0]  boot_sw;
  int          fail_count, cmp_count;

  bcr_board_regs #(.WD_LONG_CYC(LONG_CYC), .WD_SHORT_CYC(SHORT_CYC), .REVISION(REV)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .power_on_n(power_on_n), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .boot_switch_on(boot_sw),
    .option_jumper_closed(jumper), .ready_led(ready_led), .board_reset_out(board_reset_out),
    .clk_line_i(clk_level), .clk_line_o(clk_o), .clk_line_oe(clk_oe), .dat_line_i(dat_level),
    .dat_line_o(dat_o), .dat_line_oe(dat_oe));
  bcr_tw_bus far_end (.clk_oe(clk_oe), .dat_oe(dat_oe), .ext_clk_low(ext_clk_low),
    .ext_dat_low(ext_dat_low), .clk_level(clk_level), .dat_level(dat_level));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic bus_read(input logic [31:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic board_reset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  // Counts edges until the reset request rises, then measures its width.
  task automatic expect_bite(input int lo, input int hi);
    int n;
    int w;
    n = 0;
    w = 1;
    #1;
    while (board_reset_out !== 1'b1 && n < hi) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("bite_seen", 8'h01, {7'h0, board_reset_out});
    check("bite_early", 8'h00, {7'h0, n < lo});
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (board_reset_out !== 1'b1) break;
      w++;
    end
    check("pulse_len", 8'h10, w[7:0]);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    finish_test();
  end

  initial begin
    {rstn, power_on_n, bus_rd, bus_wr, jumper, ext_clk_low, ext_dat_low} = 7'h0;
    bus_addr = 32'h0;
    bus_wdata = 8'h00;
    boot_sw = 2'h0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    power_on_n <= 1'b1;
    bus_read(`BCR_ADDR_SETUP, rd_val);
    check("setup_rst", 8'h00, rd_val);
    bus_read(`BCR_ADDR_STATUS, rd_val);
    check("status_ok", 8'hff, rd_val);
    bus_write(`BCR_ADDR_REVISION, 8'h00);
    bus_read(`BCR_ADDR_REVISION, rd_val);
    check("revision", REV, rd_val);
    // The boot select register is only ever read, never written.
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      boot_sw <= i[1:0];
      bus_read(`BCR_ADDR_BOOT_SEL, rd_val);
      check("boot_sel", (i == 3) ? 8'h02 : 8'h03, rd_val);
    end
    for (int i = 1; i >= 0; i--) begin
      bus_write(`BCR_ADDR_SETUP, {i[0], 7'h0});
      bus_read(`BCR_ADDR_SETUP, rd_val);
      check("setup_led", {i[0], 7'h0}, rd_val);
      check("ready_led", {7'h0, i[0]}, {7'h0, ready_led});
    end
    // Reserved bits carry a pattern so that a latch fed from the wrong bit shows up.
    // The far end pulls both lines low in half the passes, so there the pin bits read low even where the latch bits are high.
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      ext_clk_low <= i[2];
      ext_dat_low <= i[2];
      bus_write(`BCR_ADDR_TWO_WIRE, {i[1:0], 6'h15});
      repeat (2) @(posedge sys_clk);
      check("line_oe", {6'h0, ~i[1:0]}, {6'h0, clk_oe, dat_oe});
      check("line_o", 8'h00, {6'h0, clk_o, dat_o});
      bus_read(`BCR_ADDR_TWO_WIRE, rd_val);
      check("two_wire", {i[1:0], i[1] & ~i[2], i[0] & ~i[2], 4'hf}, rd_val);
    end
    @(posedge sys_clk);
    jumper <= 1'b1;
    bus_write(`BCR_ADDR_SETUP, 8'hc0);
    bus_write(`BCR_ADDR_SETUP, 8'h80);
    bus_read(`BCR_ADDR_SETUP, rd_val);
    check("wd_no_stop", 8'hc0, rd_val);
    for (int k = 0; k < 4; k++) begin
      repeat (SHORT_CYC - 15) @(posedge sys_clk);
      bus_write(`BCR_ADDR_CONTROL, {1'b0, ~k[0], 6'h0});
      #1;
      check("kick_holds", 8'h00, {7'h0, board_reset_out});
    end
    expect_bite(SHORT_CYC - 1, SHORT_CYC + 3);
    board_reset();
    bus_read(`BCR_ADDR_STATUS, rd_val);
    check("status_expired", 8'hef, rd_val);
    bus_write(`BCR_ADDR_SETUP, 8'h40);
    expect_bite(0, 1);
    board_reset();
    bus_write(`BCR_ADDR_OPTION, 8'h5a);
    bus_read(`BCR_ADDR_STATUS, rd_val);
    check("status_kept", 8'hef, rd_val);
    bus_write(`BCR_ADDR_OPTION, 8'ha5);
    expect_bite(0, 1);
    board_reset();
    bus_read(`BCR_ADDR_STATUS, rd_val);
    check("status_cleared", 8'hff, rd_val);
    @(posedge sys_clk);
    jumper <= 1'b0;
    bus_write(`BCR_ADDR_SETUP, 8'h40);
    expect_bite(LONG_CYC - 1, LONG_CYC + 3);
    finish_test();
  end
endmodule
